// ===== hrg_top.sv
/*
 * Hybrid random generator: raw entropy bit stream with continuous health
 * tests, a seeded deterministic state, and a buffered 32-bit word output.
 * Assumes raw_bit/raw_valid come from the physical source in the clk domain.
 */
`timescale 1ns/1ps

// Operation
// - the generator state is seeded only from health-checked entropy source words.
// - a reseed request at any time forces fresh entropy seeding before any further word; a word already buffered can still be taken in the next cycle.
// - generator output is delivered as 32-bit words.
// - a total-failure test runs from start-up and a detected failure stops all output.
// - words depending on raw bits sampled after a total failure are never used.
// - a monobit online test must pass at start-up and any later defect stops output.
// - the online test runs on every raw bit without waiting for any request.
// - entropy is gathered and used only in whole 32-bit words.
module hrg_top
  import hrg_pkg::*;
#(
  parameter int REP_MAX  = REP_LIMIT,
  parameter int WINDOW   = WIN_BITS,
  parameter int ONES_LO  = MONO_LO,
  parameter int ONES_HI  = MONO_HI,
  parameter int SEED_CNT = SEED_WORDS,
  parameter int DEPTH    = BUF_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              raw_bit,
  input  wire logic              raw_valid,
  input  wire logic              reseed_req,
  input  wire logic              out_ready,
  output logic                   out_valid,
  output logic      [WORD_W-1:0] out_data,
  output logic                   gen_ready,
  output logic                   reseed_busy,
  output logic                   fail_total,
  output logic                   fail_defect
);

  localparam int REP_W  = $clog2(REP_MAX + 1);
  localparam int WIN_W  = $clog2(WINDOW + 1);
  localparam int BIT_W  = $clog2(WORD_W);
  localparam int SEED_W = $clog2(SEED_CNT + 1);
  localparam logic [REP_W-1:0]  REP_TOP   = REP_W'(REP_MAX - 1);
  localparam logic [WIN_W-1:0]  WIN_TOP   = WIN_W'(WINDOW - 1);
  localparam logic [WIN_W-1:0]  LO_BOUND  = WIN_W'(ONES_LO);
  localparam logic [WIN_W-1:0]  HI_BOUND  = WIN_W'(ONES_HI);
  localparam logic [BIT_W-1:0]  BIT_TOP   = BIT_W'(WORD_W - 1);
  localparam logic [SEED_W-1:0] SEED_TOP  = SEED_W'(SEED_CNT - 1);

  hrg_state_type      st_q;
  logic               prev_bit_q;
  logic [REP_W-1:0]   rep_cnt_q;
  logic [WIN_W-1:0]   win_cnt_q;
  logic [WIN_W-1:0]   ones_q;
  logic               startup_ok_q;
  logic [BIT_W-1:0]   bit_cnt_q;
  logic [WORD_W-1:0]  shift_q;
  logic [WORD_W-1:0]  pend_q;
  logic               have_pend_q;
  logic [WORD_W-1:0]  ent_word_q;
  logic               ent_valid_q;
  logic [SEED_W-1:0]  seed_cnt_q;
  logic [STATE_W-1:0] state_q;
  logic               reseed_pend_q;
  logic               fail_total_q;
  logic               fail_defect_q;
  logic               gen_ready_q;
  logic               reseed_busy_q;

  logic               rep_hit;
  logic               win_end;
  logic [WIN_W-1:0]   ones_now;
  logic               win_bad;
  logic               fail_now;
  logic               word_done;
  logic [WORD_W-1:0]  word_now;
  logic               gen_valid;
  logic               buf_ready;
  logic               gen_take;
  logic [STATE_W-1:0] state_step;
  logic [WORD_W-1:0]  gen_word;
  logic               flush;

  // total-failure test: run of identical raw bits
  assign rep_hit   = raw_valid && (raw_bit == prev_bit_q) && (rep_cnt_q >= REP_TOP - 1'b1);
  // monobit window test
  assign ones_now  = ones_q + WIN_W'(raw_bit);
  assign win_end   = raw_valid && (win_cnt_q == WIN_TOP);
  assign win_bad   = win_end && ((ones_now < LO_BOUND) || (ones_now > HI_BOUND));
  assign fail_now  = fail_total_q || fail_defect_q || rep_hit || win_bad;
  assign word_done = raw_valid && (bit_cnt_q == BIT_TOP);
  assign word_now  = {shift_q[WORD_W-2:0], raw_bit};

  assign state_step = {state_q[STATE_W-8:0], state_q[STATE_W-1:STATE_W-7]}
                      ^ (state_q >> 3) ^ MIX_CONST;
  assign gen_word   = state_step[STATE_W-1:STATE_W-WORD_W] ^ state_step[WORD_W-1:0];
  assign gen_valid  = (st_q == ST_RUN) && !reseed_pend_q && !fail_now;
  assign gen_take   = gen_valid && buf_ready;
  assign flush      = (st_q != ST_RUN) || fail_now || reseed_pend_q;

  // health-test counters run on every raw bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_bit_q   <= 1'b0;
      rep_cnt_q    <= '0;
      win_cnt_q    <= '0;
      ones_q       <= '0;
      startup_ok_q <= 1'b0;
    end
    else if (raw_valid)
    begin
      prev_bit_q <= raw_bit;
      rep_cnt_q  <= (raw_bit == prev_bit_q) ? rep_cnt_q + 1'b1 : '0;
      if (win_end)
      begin
        win_cnt_q <= '0;
        ones_q    <= '0;
        if (!win_bad)
        begin
          startup_ok_q <= 1'b1;
        end
      end
      else
      begin
        win_cnt_q <= win_cnt_q + 1'b1;
        ones_q    <= ones_now;
      end
    end
  end

  // sticky failure flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fail_total_q  <= 1'b0;
      fail_defect_q <= 1'b0;
    end
    else
    begin
      if (rep_hit)
      begin
        fail_total_q <= 1'b1;
      end
      if (win_bad)
      begin
        fail_defect_q <= 1'b1;
      end
    end
  end

  // raw words held back one word so a failure run is seen before release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_q   <= '0;
      shift_q     <= '0;
      pend_q      <= '0;
      have_pend_q <= 1'b0;
      ent_word_q  <= '0;
      ent_valid_q <= 1'b0;
    end
    else
    begin
      ent_valid_q <= 1'b0;
      if (raw_valid)
      begin
        shift_q   <= word_now;
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
      if (word_done)
      begin
        pend_q      <= word_now;
        have_pend_q <= !fail_now;
        if (have_pend_q && !fail_now)
        begin
          ent_word_q  <= pend_q;
          ent_valid_q <= 1'b1;
        end
      end
    end
  end

  // reseed request; a new request wins over the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reseed_pend_q <= 1'b0;
    end
    else if (reseed_req)
    begin
      reseed_pend_q <= 1'b1;
    end
    else if (st_q == ST_RUN)
    begin
      reseed_pend_q <= 1'b0;
    end
  end

  // control and generator state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q          <= ST_STARTUP;
      seed_cnt_q    <= '0;
      state_q       <= '0;
      gen_ready_q   <= 1'b0;
      reseed_busy_q <= 1'b0;
    end
    else if (fail_now)
    begin
      st_q          <= ST_FAIL;
      gen_ready_q   <= 1'b0;
      reseed_busy_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_STARTUP:
        begin
          if (startup_ok_q)
          begin
            st_q       <= ST_SEED;
            seed_cnt_q <= '0;
          end
        end
        ST_SEED:
        begin
          if (ent_valid_q)
          begin
            state_q <= state_step ^ {{(STATE_W-WORD_W){1'b0}}, ent_word_q};
            if (seed_cnt_q == SEED_TOP)
            begin
              st_q          <= ST_RUN;
              gen_ready_q   <= 1'b1;
              reseed_busy_q <= 1'b0;
            end
            else
            begin
              seed_cnt_q <= seed_cnt_q + 1'b1;
            end
          end
        end
        ST_RUN:
        begin
          if (reseed_pend_q)
          begin
            st_q          <= ST_SEED;
            seed_cnt_q    <= '0;
            gen_ready_q   <= 1'b0;
            reseed_busy_q <= 1'b1;
          end
          else if (gen_take)
          begin
            state_q <= state_step;
          end
        end
        ST_FAIL:
        begin
          st_q <= ST_FAIL;
        end
      endcase
    end
  end

  hrg_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (gen_valid),
    .in_ready  (buf_ready),
    .in_data   (gen_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign gen_ready   = gen_ready_q;
  assign reseed_busy = reseed_busy_q;
  assign fail_total  = fail_total_q;
  assign fail_defect = fail_defect_q;

endmodule

// ===== hrg_pkg.sv
/*
 * Constants shared by the hybrid random generator: word and state widths,
 * entropy health-test limits and seeding length.
 * Assumes one clock domain; the numbers are plain defaults for the top module.
 */
package hrg_pkg;

  localparam int WORD_W      = 32;
  localparam int STATE_W     = 128;
  localparam int REP_LIMIT   = 32;
  localparam int WIN_BITS    = 256;
  localparam int MONO_LO     = 96;
  localparam int MONO_HI     = 160;
  localparam int SEED_WORDS  = 4;
  localparam int BUF_DEPTH   = 2;
  localparam logic [STATE_W-1:0] MIX_CONST = 128'h9E3779B97F4A7C15F39CC0605CEDC834;

  typedef enum logic [1:0]
  {
    ST_STARTUP,
    ST_SEED,
    ST_RUN,
    ST_FAIL
  } hrg_state_type;

endpackage

// ===== hrg_buffer.sv
/*
 * Shift-style buffer with valid and ready on both sides and a flush.
 * Entry 0 is the head and drives the output straight from its flip-flops.
 * Assumes the filler holds its word while in_valid is high and in_ready low.
 */
`timescale 1ns/1ps

module hrg_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] data_q [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic             pop;
  logic             push;

  assign pop       = vld_q[0] & out_ready;
  assign in_ready  = ~vld_q[DEPTH-1];
  assign push      = in_valid & in_ready;
  assign out_valid = vld_q[0];
  assign out_data  = data_q[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      logic             nxt_vld;
      logic [WIDTH-1:0] nxt_data;
      logic             free_after;
      if (i == DEPTH - 1)
      begin : g_last
        assign nxt_vld  = 1'b0;
        assign nxt_data = data_q[i];
      end
      else
      begin : g_mid
        assign nxt_vld  = vld_q[i+1];
        assign nxt_data = data_q[i+1];
      end
      // slot takes the pushed word when it is the first free one after a pop
      if (i == 0)
      begin : g_first
        assign free_after = pop ? ~nxt_vld : ~vld_q[0];
      end
      else
      begin : g_rest
        assign free_after = pop ? (vld_q[i] & ~nxt_vld) : (vld_q[i-1] & ~vld_q[i]);
      end

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          vld_q[i]  <= 1'b0;
          data_q[i] <= '0;
        end
        else if (flush)
        begin
          vld_q[i] <= 1'b0;
        end
        else if (push && free_after)
        begin
          vld_q[i]  <= 1'b1;
          data_q[i] <= in_data;
        end
        else if (pop)
        begin
          vld_q[i]  <= nxt_vld;
          data_q[i] <= nxt_data;
        end
      end
    end
  endgenerate

endmodule

// ===== hrg_top_chk.sv
/* Port checker for hrg_top, attached by bind.
   Assumes one clock domain, rst asynchronous active high. */
`timescale 1ns/1ps
module hrg_top_chk
  import hrg_pkg::*;
#(
  parameter int REP_MAX = REP_LIMIT
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              raw_bit,
  input wire logic              raw_valid,
  input wire logic              reseed_req,
  input wire logic              out_ready,
  input wire logic              out_valid,
  input wire logic [WORD_W-1:0] out_data,
  input wire logic              gen_ready,
  input wire logic              reseed_busy,
  input wire logic              fail_total,
  input wire logic              fail_defect
);
  int   run_q;
  logic last_q;
  wire  dead = fail_total || fail_defect;

  // length of the current run of equal raw bits
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      run_q  <= 0;
      last_q <= 1'b0;
    end
    else if (raw_valid)
    begin
      run_q  <= (raw_bit == last_q) ? run_q + 1 : 1;
      last_q <= raw_bit;
    end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_reseed_taken;
    reseed_req && gen_ready;
  endsequence
  sequence s_seed_begun;
    ##2 ((reseed_busy && !gen_ready) || dead);
  endsequence

  a_fail_blocks_out: assert property (dead |-> ##2 (!out_valid && !gen_ready))
    else $error("output present after a failure");
  a_total_sticky: assert property (fail_total |=> fail_total)
    else $error("total failure flag cleared");
  a_defect_sticky: assert property (fail_defect |=> fail_defect)
    else $error("defect flag cleared");
  a_rep_detect: assert property (raw_valid && raw_bit == last_q && run_q >= REP_MAX - 1
    |=> fail_total)
    else $error("long run of equal bits not flagged");
  a_hold_stall: assert property (out_valid && !out_ready |=>
    (out_valid && $stable(out_data)) || !gen_ready || dead || $past(reseed_req))
    else $error("stalled word changed or lost");
  a_idle_no_word: assert property (!gen_ready && !$past(gen_ready) |-> !out_valid)
    else $error("word offered while not running");
  a_reseed_flush: assert property (reseed_req |-> ##2 !out_valid)
    else $error("word offered right after reseed request");
  a_reseed_seeds: assert property (s_reseed_taken |-> s_seed_begun)
    else $error("reseed did not start seeding");
endmodule

bind hrg_top hrg_top_chk #(.REP_MAX(REP_MAX)) hrg_top_chk_inst (.clk, .rst, .raw_bit,
  .raw_valid, .reseed_req, .out_ready, .out_valid, .out_data, .gen_ready, .reseed_busy,
  .fail_total, .fail_defect);

// ===== hrg_consumer.sv
/* Word consumer standing for the requesting logic.
   Assumes pace 0 always takes, 1 stalls at random, 2 never takes. */
`timescale 1ns/1ps
module hrg_consumer
  import hrg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [1:0]        pace,
  input  wire logic              out_valid,
  input  wire logic [WORD_W-1:0] out_data,
  output logic                   out_ready,
  output int                     words
);
  initial out_ready = 1'b0;

  always @(negedge clk)
    out_ready <= (pace == 2'h0) || (pace == 2'h1 && $urandom_range(3) == 0);

  // whole words only, counted on the handshake
  always @(posedge clk or posedge rst)
    if (rst)
      words <= 0;
    else if (out_valid && out_ready)
      words <= words + 1;
endmodule

// ===== hrg_top_bench.sv
/* Self-checking bench for hrg_top with shortened health-test limits.
   Assumes the consumer model in hrg_consumer. */
`timescale 1ns/1ps
module hrg_top_bench;
  import hrg_pkg::*;
  logic              clk;
  logic              rst;
  logic              raw_bit;
  logic              raw_valid;
  logic              reseed_req;
  logic              out_ready;
  logic              out_valid;
  logic [WORD_W-1:0] out_data;
  logic [WORD_W-1:0] held;
  logic              gen_ready;
  logic              reseed_busy;
  logic              fail_total;
  logic              fail_defect;
  logic [1:0]        pace;
  logic [1:0]        mode;
  logic [4:0]        fl;
  logic [4:0]        note_q[$];
  int                words;
  int                base;
  int                bit_n;
  int                error_cnt;
  int                n_checks;
  event              look;

  assign fl = {out_valid, gen_ready, reseed_busy, fail_total, fail_defect};

  hrg_top #(.REP_MAX(16), .WINDOW(64), .ONES_LO(16), .ONES_HI(48), .SEED_CNT(1))
    hrg_top_inst (.clk, .rst, .raw_bit, .raw_valid, .reseed_req, .out_ready, .out_valid,
    .out_data, .gen_ready, .reseed_busy, .fail_total, .fail_defect);
  hrg_consumer hrg_consumer_inst (.clk, .rst, .pace, .out_valid, .out_data, .out_ready,
    .words);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // raw source: balanced pairs, stuck low, or biased high
  always @(negedge clk)
  begin
    bit_n <= bit_n + 1;
    raw_valid <= 1'b1;
    case (mode)
      2'h1: raw_bit <= 1'b0;
      2'h2: raw_bit <= (bit_n % 8 != 7);
      default: raw_bit <= bit_n[0] ? ~raw_bit : 1'($urandom_range(1));
    endcase
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [4:0] e);
    note_q.push_back(e);
    -> look;
  endtask

  always @(look)
    while (note_q.size() > 0)
      chk({27'h0, fl}, {27'h0, note_q.pop_front()});

  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_for(input int b, input int n);
    repeat (n)
    begin
      @(negedge clk);
      if (fl[b] === 1'b1)
        return;
    end
    error_cnt++;
    test_done();
  endtask

  task automatic restart(input logic [1:0] m);
    rst = 1'b1;
    mode = m;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic reseed();
    reseed_req = 1'b1;
    @(negedge clk);
    reseed_req = 1'b0;
  endtask

  initial
  begin
    rst = 1'b1;
    raw_valid = 1'b0;
    raw_bit = 1'b0;
    bit_n = 0;
    reseed_req = 1'b0;
    pace = 2'h2;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(3));
    restart(2'h0);
    note(5'h00);
    wait_for(3, 400);
    repeat (3) @(negedge clk);
    base = words;
    held = out_data;
    repeat (10) @(negedge clk);
    note(5'h18);
    chk(words, base);
    chk(out_data, held);
    pace = 2'h1;
    repeat (100) @(negedge clk);
    pace = 2'h0;
    repeat (50) @(negedge clk);
    chk(32'(words > base), 32'h1);
    pace = 2'h2;
    reseed();
    repeat (2) @(negedge clk);
    note(5'h04);
    reseed();
    wait_for(3, 400);
    repeat (300) @(negedge clk);
    note(5'h18);
    mode = 2'h1;
    wait_for(1, 60);
    mode = 2'h0;
    repeat (2) @(negedge clk);
    note(5'h02);
    repeat (200) @(negedge clk);
    note(5'h02);
    restart(2'h1);
    repeat (300) @(negedge clk);
    note(5'h03);
    restart(2'h2);
    wait_for(0, 200);
    repeat (200) @(negedge clk);
    note(5'h01);
    test_done();
  end
endmodule
